// *** rtl/pfs_pkg.sv ***
// package: register map, fields, reset values and states of the pcm framer/synchroniser
package pfs_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PAT_LO = 8'h04;
	localparam logic [7:0] OFF_SYNC_CFG = 8'h08;
	localparam logic [7:0] OFF_FRAME = 8'h0C;
	localparam logic [7:0] OFF_THRESH = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// control bits
	localparam int CTRL_GEN_EN = 0;
	localparam int CTRL_SYNC_EN = 1;
	localparam int CTRL_IDX_EN = 2;
	localparam int CTRL_STRIP = 3;
	localparam int CTRL_INT_SRC = 4;
	localparam int CTRL_LOCK_TO_RXL = 5;
	localparam int CTRL_IDXV_TO_RXL = 6;
	localparam int CTRL_LOCK_TO_AHD = 7;
	localparam int CTRL_IDXV_TO_AHD = 8;
	// field positions
	localparam int SYNC_PAT_HI_POS = 0;
	localparam int SYNC_LEN_POS = 8;
	localparam int FRAME_LAST_POS = 0;
	localparam int FRAME_Z_POS = 16;
	localparam int FRAME_IDXW_POS = 28;
	localparam int TH_MATCH_POS = 0;
	localparam int TH_WIN_POS = 8;
	localparam int TH_ACQ_POS = 16;
	localparam int TH_DROP_POS = 24;
	localparam int ST_STATE_POS = 0;
	localparam int ST_LOCK_POS = 2;
	localparam int ST_IDXV_POS = 3;
	localparam int ST_IDX_POS = 16;
	// pattern length limits
	localparam logic [5:0] PAT_LEN_MIN = 6'h10;
	localparam logic [5:0] PAT_LEN_MAX = 6'h21;
	// reset values
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_PAT_LO = 32'h0000_EB90;
	localparam logic [31:0] RST_SYNC_CFG = 32'h0000_1000;
	localparam logic [31:0] RST_FRAME = 32'h7004_00FF;
	localparam logic [31:0] RST_THRESH = 32'h0303_0110;
	typedef enum logic [1:0] {
		PFS_SEARCH = 2'b00,
		PFS_CHECK = 2'b01,
		PFS_LOCK = 2'b10
	} pfs_state_t;
endpackage

// *** rtl/pfs_gen.sv ***
// minor/major frame generator: sync pattern, optional index word, streamed data
`timescale 1ns/1ns
`default_nettype none
module pfs_gen #(
	parameter int FL_W = 14,
	parameter int ZW = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic idx_en,
	input wire logic use_internal,
	input wire logic [32:0] pattern,
	input wire logic [5:0] pat_len,
	input wire logic [FL_W-1:0] frame_last,
	input wire logic [ZW-1:0] major_len,
	input wire logic [3:0] idx_last,
	input wire logic ext_bit,
	output logic tx_bit,
	output logic tx_frame_start,
	output logic ext_take
);
	logic [FL_W-1:0] pos_reg;
	logic [ZW-1:0] minor_reg;
	logic [14:0] lfsr_reg;
	logic in_sync;
	logic in_idx;
	logic [FL_W-1:0] idx_off;
	logic [15:0] idx_word;
	logic bit_next;

	////////////////////////////////////////////////////////////////////////////
	// minor position and index count 1..Z
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_reg <= '0;
			minor_reg <= ZW'(1);
		end else if (!enable) begin
			pos_reg <= '0;
			minor_reg <= ZW'(1);
		end else if (pos_reg >= frame_last) begin
			pos_reg <= '0;
			minor_reg <= (minor_reg >= major_len) ? ZW'(1) : minor_reg + ZW'(1);
		end else begin
			pos_reg <= pos_reg + FL_W'(1);
		end
	end

	// sync first, then index word, then data
	always_comb begin
		in_sync = pos_reg < FL_W'(pat_len);
		idx_off = pos_reg - FL_W'(pat_len);
		// index only in word 1 when enabled
		in_idx = idx_en && !in_sync && (idx_off <= FL_W'(idx_last));
		idx_word = 16'(minor_reg) >> (idx_last - idx_off[3:0]);
		if (in_sync) begin
			bit_next = pattern[6'(pat_len - 6'(pos_reg) - 6'h01)];
		end else if (in_idx) begin
			bit_next = idx_word[0];
		end else begin
			// consecutive source bits, no word alignment
			bit_next = use_internal ? lfsr_reg[14] : ext_bit;
		end
	end

	// internal pattern generator advances only on data bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lfsr_reg <= 15'h7FFF;
		end else if (enable && use_internal && !in_sync && !in_idx) begin
			lfsr_reg <= {lfsr_reg[13:0], lfsr_reg[14] ^ lfsr_reg[13]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_bit <= 1'b0;
			tx_frame_start <= 1'b0;
			ext_take <= 1'b0;
		end else begin
			tx_bit <= enable & bit_next;
			tx_frame_start <= enable && (pos_reg == '0);
			ext_take <= enable && !use_internal && !in_sync && !in_idx;
		end
	end
endmodule // pfs_gen
`default_nettype wire

// *** rtl/pfs_top.sv ***
// pcm frame generator and frame synchroniser with ahb-lite register slave
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Function
// - major frames up to 256 minor frames
// - minor frames fixed length up to 16384
// - sync pattern value and length 16-33
// - generator inserts index word at word 1
// - optional index check, word 1 only
// - frame is sync, index, data; index 1..Z
// - data bits streamed, no word alignment
// - slip window accepts early or late sync
// - matching-bit threshold declares sync detect
// - acquire count of detects declares lock
// - drop count of misses loses lock
// - search examines every bit alignment
// - check locks after consecutive expected detects
// - lock held until consecutive misses reach count
// - index checked only while locked
// - index valid if previous plus one, wraps
// - optional stripping of sync and index
// - lock/index-valid routable to two pins
module pfs_top #(
	parameter int FL_W = 14,
	parameter int ZW = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_data_pin,
	output logic tx_bit,
	output logic tx_frame_start,
	output logic ext_take,
	input wire logic rx_bit_pin,
	output logic rx_data,
	output logic rx_data_valid,
	output logic receiver_lock_pin,
	output logic all_high_detect_pin
);
	logic [31:0] ctrl_reg;
	logic [31:0] pat_lo_reg;
	logic [31:0] sync_cfg_reg;
	logic [31:0] frame_reg;
	logic [31:0] thresh_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [1:0] ext_sync_reg;
	logic [1:0] rx_sync_reg;
	logic [32:0] shift_reg;
	pfs_pkg::pfs_state_t state_reg;
	logic [FL_W:0] cnt_reg;
	logic [7:0] hits_reg;
	logic [7:0] miss_reg;
	logic [15:0] idx_sh_reg;
	logic [15:0] prev_idx_reg;
	logic prev_ok_reg;
	logic idx_valid_reg;
	logic [32:0] pattern;
	logic [5:0] pat_len;
	logic [FL_W-1:0] frame_last;
	logic [ZW-1:0] major_len;
	logic [3:0] idx_last;
	logic [5:0] match_th;
	logic [2:0] win;
	logic [7:0] acq_cnt;
	logic [7:0] drop_cnt;
	logic rx_in;
	logic detect;
	logic in_win;
	logic win_end;
	logic locked;
	logic [15:0] idx_now;
	logic [FL_W:0] data_first;
	logic [FL_W:0] data_last;

	// count of agreeing bits over the active pattern length
	function automatic logic [5:0] pfs_match(input logic [32:0] rx, input logic [32:0] pat,
		input logic [5:0] len);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 33; i++) begin
			if ((6'(i) < len) && (rx[i] == pat[i])) begin
				n = n + 6'h01;
			end
		end
		return n;
	endfunction

	// pattern length forced into its legal range
	function automatic logic [5:0] pfs_clamp_len(input logic [5:0] v);
		if (v < pfs_pkg::PAT_LEN_MIN) begin
			return pfs_pkg::PAT_LEN_MIN;
		end else if (v > pfs_pkg::PAT_LEN_MAX) begin
			return pfs_pkg::PAT_LEN_MAX;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= pfs_pkg::RST_CTRL;
			pat_lo_reg <= pfs_pkg::RST_PAT_LO;
			sync_cfg_reg <= pfs_pkg::RST_SYNC_CFG;
			frame_reg <= pfs_pkg::RST_FRAME;
			thresh_reg <= pfs_pkg::RST_THRESH;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				pfs_pkg::OFF_CTRL: ctrl_reg <= {23'h000000, hwdata[8:0]};
				pfs_pkg::OFF_PAT_LO: pat_lo_reg <= hwdata;
				pfs_pkg::OFF_SYNC_CFG: sync_cfg_reg <= {18'h00000,
					pfs_clamp_len(hwdata[pfs_pkg::SYNC_LEN_POS +: 6]), 7'h00, hwdata[0]};
				pfs_pkg::OFF_FRAME: frame_reg <= hwdata & 32'hF1FF_3FFF;
				pfs_pkg::OFF_THRESH: thresh_reg <= hwdata & 32'hFFFF_073F;
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr)
				pfs_pkg::OFF_CTRL: hrdata <= ctrl_reg;
				pfs_pkg::OFF_PAT_LO: hrdata <= pat_lo_reg;
				pfs_pkg::OFF_SYNC_CFG: hrdata <= sync_cfg_reg;
				pfs_pkg::OFF_FRAME: hrdata <= frame_reg;
				pfs_pkg::OFF_THRESH: hrdata <= thresh_reg;
				pfs_pkg::OFF_STATUS: hrdata <= {prev_idx_reg, 12'h000, idx_valid_reg, locked, state_reg};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field decode
	always_comb begin
		pattern = {sync_cfg_reg[pfs_pkg::SYNC_PAT_HI_POS], pat_lo_reg};
		pat_len = sync_cfg_reg[pfs_pkg::SYNC_LEN_POS +: 6];
		// minor frame length field, up to 16384 bits
		frame_last = frame_reg[pfs_pkg::FRAME_LAST_POS +: FL_W];
		// major frame length Z, up to 256
		major_len = frame_reg[pfs_pkg::FRAME_Z_POS +: ZW];
		idx_last = frame_reg[pfs_pkg::FRAME_IDXW_POS +: 4];
		match_th = thresh_reg[pfs_pkg::TH_MATCH_POS +: 6];
		win = thresh_reg[pfs_pkg::TH_WIN_POS +: 3];
		acq_cnt = thresh_reg[pfs_pkg::TH_ACQ_POS +: 8];
		drop_cnt = thresh_reg[pfs_pkg::TH_DROP_POS +: 8];
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync_reg <= 2'b00;
			rx_sync_reg <= 2'b00;
		end else begin
			ext_sync_reg <= {ext_sync_reg[0], ext_data_pin};
			rx_sync_reg <= {rx_sync_reg[0], rx_bit_pin};
		end
	end

	assign rx_in = rx_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////
	// generator
	pfs_gen #(
		.FL_W(FL_W),
		.ZW(ZW)
	) u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.enable(ctrl_reg[pfs_pkg::CTRL_GEN_EN]),
		.idx_en(ctrl_reg[pfs_pkg::CTRL_IDX_EN]),
		.use_internal(ctrl_reg[pfs_pkg::CTRL_INT_SRC]),
		.pattern(pattern),
		.pat_len(pat_len),
		.frame_last(frame_last),
		.major_len(major_len),
		.idx_last(idx_last),
		.ext_bit(ext_sync_reg[1]),
		.tx_bit(tx_bit),
		.tx_frame_start(tx_frame_start),
		.ext_take(ext_take)
	);

	////////////////////////////////////////////////////////////////////////////
	// synchroniser: correlation and window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= {shift_reg[31:0], rx_in};
		end
	end

	always_comb begin
		// every alignment correlated against the threshold
		detect = pfs_match({shift_reg[31:0], rx_in}, pattern, pat_len) >= match_th;
		// slip window around the expected sync end
		in_win = (cnt_reg + (FL_W + 1)'(win)) >= (FL_W + 1)'(frame_last);
		win_end = cnt_reg >= ((FL_W + 1)'(frame_last) + (FL_W + 1)'(win));
		locked = state_reg == pfs_pkg::PFS_LOCK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= pfs_pkg::PFS_SEARCH;
			cnt_reg <= '0;
			hits_reg <= 8'h00;
			miss_reg <= 8'h00;
		end else if (!ctrl_reg[pfs_pkg::CTRL_SYNC_EN]) begin
			state_reg <= pfs_pkg::PFS_SEARCH;
			cnt_reg <= '0;
			hits_reg <= 8'h00;
			miss_reg <= 8'h00;
		end else begin
			case (state_reg)
				pfs_pkg::PFS_SEARCH: begin
					// any bit position may start the frame
					if (detect) begin
						cnt_reg <= '0;
						hits_reg <= 8'h01;
						miss_reg <= 8'h00;
						state_reg <= (acq_cnt <= 8'h01) ? pfs_pkg::PFS_LOCK : pfs_pkg::PFS_CHECK;
					end
				end
				pfs_pkg::PFS_CHECK: begin
					if (in_win && detect) begin
						cnt_reg <= '0;
						hits_reg <= hits_reg + 8'h01;
						// consecutive expected detects reach acquire count
						if (hits_reg + 8'h01 >= acq_cnt) begin
							state_reg <= pfs_pkg::PFS_LOCK;
							miss_reg <= 8'h00;
						end
					end else if (win_end) begin
						state_reg <= pfs_pkg::PFS_SEARCH;
						hits_reg <= 8'h00;
						cnt_reg <= '0;
					end else begin
						cnt_reg <= cnt_reg + (FL_W + 1)'(1);
					end
				end
				pfs_pkg::PFS_LOCK: begin
					if (in_win && detect) begin
						cnt_reg <= '0;
						miss_reg <= 8'h00;
					end else if (win_end) begin
						if (miss_reg + 8'h01 >= drop_cnt) begin
							state_reg <= pfs_pkg::PFS_SEARCH;
							miss_reg <= 8'h00;
							hits_reg <= 8'h00;
							cnt_reg <= '0;
						end else begin
							miss_reg <= miss_reg + 8'h01;
							cnt_reg <= (FL_W + 1)'(win);
						end
					end else begin
						cnt_reg <= cnt_reg + (FL_W + 1)'(1);
					end
				end
				default: begin
					state_reg <= pfs_pkg::PFS_SEARCH;
					cnt_reg <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// index word check
	assign idx_now = {idx_sh_reg[14:0], rx_in};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_sh_reg <= 16'h0000;
		end else begin
			idx_sh_reg <= (cnt_reg == '0) ? {15'h0000, rx_in} : idx_now;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_idx_reg <= 16'h0000;
			prev_ok_reg <= 1'b0;
			idx_valid_reg <= 1'b0;
		end else if (!locked || !ctrl_reg[pfs_pkg::CTRL_IDX_EN]) begin
			// no checking and no stored index outside lock
			prev_idx_reg <= 16'h0000;
			prev_ok_reg <= 1'b0;
			idx_valid_reg <= 1'b0;
		// index taken from word 1 only
		end else if (cnt_reg == (FL_W + 1)'(idx_last)) begin
			prev_idx_reg <= idx_now;
			prev_ok_reg <= 1'b1;
			// successor or wrap from Z to 1
			idx_valid_reg <= prev_ok_reg && ((idx_now == prev_idx_reg + 16'h0001)
				|| ((idx_now == 16'h0001) && (prev_idx_reg == 16'(major_len))));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data output and indication pins
	always_comb begin
		data_first = ctrl_reg[pfs_pkg::CTRL_IDX_EN] ?
			(FL_W + 1)'(idx_last) + (FL_W + 1)'(1) : '0;
		data_last = (FL_W + 1)'(frame_last) - (FL_W + 1)'(pat_len);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_data <= 1'b0;
			rx_data_valid <= 1'b0;
		end else begin
			rx_data <= rx_in;
			// strip keeps only locked frame data bits
			if (ctrl_reg[pfs_pkg::CTRL_STRIP]) begin
				rx_data_valid <= locked && (cnt_reg >= data_first) && (cnt_reg <= data_last);
			end else begin
				rx_data_valid <= ctrl_reg[pfs_pkg::CTRL_SYNC_EN];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			receiver_lock_pin <= 1'b0;
			all_high_detect_pin <= 1'b0;
		end else begin
			receiver_lock_pin <= (ctrl_reg[pfs_pkg::CTRL_LOCK_TO_RXL] & locked)
				| (ctrl_reg[pfs_pkg::CTRL_IDXV_TO_RXL] & idx_valid_reg);
			all_high_detect_pin <= (ctrl_reg[pfs_pkg::CTRL_LOCK_TO_AHD] & locked)
				| (ctrl_reg[pfs_pkg::CTRL_IDXV_TO_AHD] & idx_valid_reg);
		end
	end
endmodule // pfs_top
`default_nettype wire

// *** verification/pfs_src.sv ***
// far-side serial source: frames of sync word, index word and data bits
`timescale 1ns/1ns
`default_nettype none
module pfs_src #(
	parameter int FRAME_BITS = 256,
	parameter int MAJOR = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bad_sync,
	input wire logic bad_idx,
	output logic bit_out,
	output logic data_out
);
	localparam logic [15:0] PAT = 16'hEB90;
	int pos;
	logic [7:0] idx;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos <= 0;
			idx <= 8'h01;
			bit_out <= 1'b0;
			data_out <= 1'b0;
		end else begin
			pos <= (pos == FRAME_BITS - 1) ? 0 : pos + 1;
			if (pos == FRAME_BITS - 1)
				idx <= (idx == 8'(MAJOR)) ? 8'h01 : idx + 8'h01;
			data_out <= ~data_out;
			// faults only while the bench asks for them
			if (pos < 16)
				bit_out <= PAT[15 - pos] ^ (bad_sync && pos == 0);
			else if (pos < 24)
				bit_out <= idx[23 - pos] ^ (bad_idx && pos == 16);
			else
				bit_out <= pos[1];
		end
	end
endmodule // pfs_src
`default_nettype wire

// *** verification/pfs_top_sva.sv ***
// checker: port-level assertions of the pcm framer/synchroniser
`timescale 1ns/1ns
`default_nettype none
module pfs_top_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic tx_bit,
	input wire logic tx_frame_start,
	input wire logic ext_take,
	input wire logic rx_data_valid,
	input wire logic receiver_lock_pin,
	input wire logic all_high_detect_pin
);
	logic aw;
	logic ar;
	logic [31:0] ctrl_q;
	wire logic take = hsel && hready && htrans[1];
	wire logic gen_on = ctrl_q[pfs_pkg::CTRL_GEN_EN];
	wire logic sy_on = ctrl_q[pfs_pkg::CTRL_SYNC_EN];
	wire logic int_src = ctrl_q[pfs_pkg::CTRL_INT_SRC];
	wire logic rxl_rt = |ctrl_q[6:5];
	wire logic ahd_rt = |ctrl_q[8:7];
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// shadow of the control word and of unmapped reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw <= 1'b0;
			ar <= 1'b0;
		end else begin
			aw <= take && hwrite && haddr == pfs_pkg::OFF_CTRL;
			ar <= take && !hwrite && haddr > pfs_pkg::OFF_STATUS;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_q <= 32'h0000_0000;
		else if (aw)
			ctrl_q <= hwdata;
	end
	////////////////////////////////////////
	zero_wait_a: assert property (hreadyout)
		else $error("wait state inserted");
	okay_resp_a: assert property (!hresp)
		else $error("error response");
	unmapped_zero_a: assert property (ar |-> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	gen_idle_a: assert property (
		!gen_on && !$past(gen_on) && !$past(gen_on, 2) |-> !tx_bit && !tx_frame_start && !ext_take)
		else $error("generator active while off");
	sync_no_take_a: assert property (tx_frame_start |-> !ext_take ##1 !ext_take [*8])
		else $error("data taken inside sync word");
	frame_space_a: assert property (tx_frame_start |=> !tx_frame_start [*8])
		else $error("frames too close");
	int_src_a: assert property (int_src && $past(int_src) && $past(int_src, 2) |-> !ext_take)
		else $error("external bit taken on internal source");
	rxl_route_a: assert property (receiver_lock_pin |-> $past(rxl_rt) || $past(rxl_rt, 2))
		else $error("receiver lock pin not routed");
	ahd_route_a: assert property (all_high_detect_pin |-> $past(ahd_rt) || $past(ahd_rt, 2))
		else $error("all-high pin not routed");
	valid_gate_a: assert property (
		rx_data_valid |-> $past(sy_on) || $past(sy_on, 2) || $past(sy_on, 3))
		else $error("rx valid without sync enable");
endmodule // pfs_top_sva
bind pfs_top pfs_top_sva u_pfs_top_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .tx_bit(tx_bit), .tx_frame_start(tx_frame_start), .ext_take(ext_take),
	.rx_data_valid(rx_data_valid), .receiver_lock_pin(receiver_lock_pin),
	.all_high_detect_pin(all_high_detect_pin));
`default_nettype wire

// *** verification/pfs_top_bench.sv ***
// self-checking bench of the pcm framer/synchroniser
`timescale 1ns/1ns
`default_nettype none
module pfs_top_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic bad_sync = 1'b0;
	logic bad_idx = 1'b0;
	logic hreadyout, hresp, tx_bit, tx_frame_start, ext_take, rx_data_valid;
	logic receiver_lock_pin, all_high_detect_pin, rx_bit_pin, ext_data_pin, rx_data;
	logic [31:0] hrdata;
	logic [31:0] rd;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	wire logic hready = hreadyout;
	wire logic [2:0] pins = {tx_frame_start, all_high_detect_pin, receiver_lock_pin};
	always #10 hclk = ~hclk;
	pfs_top u_pfs_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ext_data_pin(ext_data_pin), .tx_bit(tx_bit),
		.tx_frame_start(tx_frame_start), .ext_take(ext_take), .rx_bit_pin(rx_bit_pin), .rx_data(rx_data),
		.rx_data_valid(rx_data_valid), .receiver_lock_pin(receiver_lock_pin),
		.all_high_detect_pin(all_high_detect_pin));
	pfs_src u_pfs_src (.clk(hclk), .rst_n(hresetn), .bad_sync(bad_sync), .bad_idx(bad_idx),
		.bit_out(rx_bit_pin), .data_out(ext_data_pin));
	////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single transfer; returns at the following falling edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(negedge hclk);
	endtask
	task automatic poll(input int sel, input logic v, output int n);
		n = 0;
		while (pins[sel] !== v) begin
			@(negedge hclk);
			n++;
		end
	endtask
	task automatic cap(output logic [23:0] v, output int n);
		poll(2, 1'b1, n);
		for (int i = 0; i < 24; i++) begin
			v = {v[22:0], tx_bit};
			@(negedge hclk);
		end
		poll(2, 1'b1, n);
		n += 24;
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] exp [7] = '{pfs_pkg::RST_CTRL, pfs_pkg::RST_PAT_LO, pfs_pkg::RST_SYNC_CFG,
			pfs_pkg::RST_FRAME, pfs_pkg::RST_THRESH, 32'h0000_0000, 32'h0000_0000};
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0000_0000);
			chk(rd, exp[i]);
		end
		bus(1'b1, pfs_pkg::OFF_SYNC_CFG, 32'h0000_3F00);
		bus(1'b0, pfs_pkg::OFF_SYNC_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_2100);
		bus(1'b1, pfs_pkg::OFF_SYNC_CFG, 32'h0000_0F00);
		bus(1'b0, pfs_pkg::OFF_SYNC_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_1000);
		bus(1'b1, pfs_pkg::OFF_STATUS, 32'hFFFF_FFFF);
		bus(1'b0, pfs_pkg::OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("registers done");
	endtask
	task automatic t_gen();
		logic [23:0] a;
		logic [23:0] b;
		int n;
		int m;
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0005);
		cap(a, n);
		cap(b, m);
		chk(a[23:8], 32'h0000_EB90);
		chk(n, 256);
		chk(b[7:0], (a[7:0] == 8'h04) ? 8'h01 : a[7:0] + 8'h01);
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0015);
		cap(a, n);
		chk(a[23:8], 32'h0000_EB90);
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0000);
		$display("generator done");
	endtask
	task automatic t_lock();
		int n;
		int m;
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0126);
		poll(0, 1'b1, n);
		chk(n >= 512 && n < 1300, 1);
		bus(1'b0, pfs_pkg::OFF_STATUS, 32'h0000_0000);
		chk(rd & 32'h7, 32'h6);
		poll(1, 1'b1, n);
		chk(n < 1024, 1);
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_012E);
		repeat (256) @(negedge hclk);
		n = 0;
		m = 0;
		repeat (256) begin
			@(negedge hclk);
			n += rx_data_valid;
			m += rx_data_valid & rx_data;
		end
		chk(n, 232);
		// data bits follow the source's 0011 pattern: half of them are ones
		chk(m, 116);
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0126);
		$display("lock done");
	endtask
	task automatic t_idx();
		int n;
		bad_idx = 1'b1;
		poll(1, 1'b0, n);
		chk(n < 300, 1);
		bad_idx = 1'b0;
		chk(receiver_lock_pin, 1);
		poll(1, 1'b1, n);
		chk(n < 800, 1);
		n = 0;
		repeat (1280) begin
			@(negedge hclk);
			n += (all_high_detect_pin !== 1'b1);
		end
		chk(n, 0);
		$display("index done");
	endtask
	task automatic t_loss();
		int n;
		// lock routed to the all-high pin, index-valid to the receiver-lock pin
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_00C6);
		bad_sync = 1'b1;
		repeat (300) @(negedge hclk);
		chk(all_high_detect_pin, 1);
		poll(1, 1'b0, n);
		chk(n < 600, 1);
		bus(1'b0, pfs_pkg::OFF_STATUS, 32'h0000_0000);
		chk(rd & 32'hF, 32'h0);
		bad_sync = 1'b0;
		bus(1'b1, pfs_pkg::OFF_CTRL, 32'h0000_0000);
		$display("loss done");
	endtask
	initial begin
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_gen();
		t_lock();
		t_idx();
		t_loss();
		results();
	end
endmodule // pfs_top_bench
`default_nettype wire
